/* File: src/qtx_pkg.sv */
package qtx_pkg;
  // APB register map, word aligned byte addresses.
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;

  // Control register field positions.
  localparam int CTRL_ENC_EN    = 0;
  localparam int CTRL_SELFTEST  = 1;
  localparam int CTRL_LOOPBACK  = 2;
  localparam int CTRL_DRV_LO    = 3;
  localparam int CTRL_RATE      = 5;
  localparam int CTRL_SPD_LO    = 6;
  localparam int CTRL_CODE_SET  = 8;
  localparam int CTRL_ALIGN_RST = 9;
  localparam int CTRL_RX_REFCLK = 10;
  localparam int CTRL_WIDTH     = 11;
  localparam logic [10:0] CTRL_RESET = 11'h201;

  // Status register field positions.
  localparam int STAT_ALIGN_ERR = 0;
  localparam int STAT_WS_ACTIVE = 1;
  localparam int STAT_SELFTEST  = 2;
  localparam int STAT_DISPARITY = 3;
  localparam int STAT_POWERED   = 4;
  localparam int STAT_CFG_BAD   = 5;
  localparam int STAT_MULT_LO   = 8;

  // Speed range encodings.
  localparam logic [1:0] SPD_LOW  = 2'h0;
  localparam logic [1:0] SPD_MID  = 2'h1;
  localparam logic [1:0] SPD_HIGH = 2'h2;

  // Clock multiplication factors for the two reference rates.
  localparam logic [4:0] MULT_FULL = 5'h0A;
  localparam logic [4:0] MULT_HALF = 5'h14;

  // Character timing in bit clocks.
  localparam logic [3:0] BIT_LAST  = 4'h9;
  localparam logic [3:0] TAKE_PRE  = 4'h7;
  localparam logic [3:0] TAKE_PT   = 4'h8;
  localparam logic [3:0] ENC_PT    = 4'h9;
  localparam logic [3:0] CLK_HALF  = 4'h5;

  // Transmit control codes.
  localparam logic [1:0] CT_DATA = 2'h0;
  localparam logic [1:0] CT_FILL = 2'h1;
  localparam logic [1:0] CT_SPEC = 2'h2;
  localparam logic [1:0] CT_SYNC = 2'h3;

  // Character constants.
  localparam logic [7:0] K28_5       = 8'hBC;
  localparam logic [3:0] WS_REST     = 4'hF;
  localparam logic [8:0] LFSR_SEED   = 9'h1FF;
  localparam logic [9:0] VIOL_RD_NEG = 10'h2F8;
  localparam logic [9:0] VIOL_RD_POS = 10'h107;
  localparam logic [3:0] SET1_COUNT  = 4'hC;
endpackage

/* File: src/qtx_encoder.sv */
`timescale 1ns/1ps
// Registered 8B/10B encoder with bypass and violation insertion.
module qtx_encoder (
  // Clock and reset.
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Character in.
  input  wire logic       load,
  input  wire logic [7:0] data,
  input  wire logic       is_k,
  input  wire logic       viol,
  input  wire logic       bypass,
  input  wire logic [9:0] raw,
  // Code out, bit 0 is a and bit 9 is j.
  output logic      [9:0] code,
  output logic            rd
);

  // Six bit sub-block for negative disparity, a in the top bit.
  function automatic logic [5:0] tab6(input logic [4:0] x);
    case (x)
      5'h00: tab6 = 6'h27;  5'h01: tab6 = 6'h1D;  5'h02: tab6 = 6'h2D;
      5'h03: tab6 = 6'h31;  5'h04: tab6 = 6'h35;  5'h05: tab6 = 6'h29;
      5'h06: tab6 = 6'h19;  5'h07: tab6 = 6'h38;  5'h08: tab6 = 6'h39;
      5'h09: tab6 = 6'h25;  5'h0A: tab6 = 6'h15;  5'h0B: tab6 = 6'h34;
      5'h0C: tab6 = 6'h0D;  5'h0D: tab6 = 6'h2C;  5'h0E: tab6 = 6'h1C;
      5'h0F: tab6 = 6'h17;  5'h10: tab6 = 6'h1B;  5'h11: tab6 = 6'h23;
      5'h12: tab6 = 6'h13;  5'h13: tab6 = 6'h32;  5'h14: tab6 = 6'h0B;
      5'h15: tab6 = 6'h2A;  5'h16: tab6 = 6'h1A;  5'h17: tab6 = 6'h3A;
      5'h18: tab6 = 6'h33;  5'h19: tab6 = 6'h26;  5'h1A: tab6 = 6'h16;
      5'h1B: tab6 = 6'h36;  5'h1C: tab6 = 6'h0E;  5'h1D: tab6 = 6'h2E;
      5'h1E: tab6 = 6'h1E;  default: tab6 = 6'h2B;
    endcase
  endfunction

  // Four bit sub-block for negative disparity, f in the top bit.
  function automatic logic [3:0] tab4(input logic [2:0] y);
    case (y)
      3'h0: tab4 = 4'hB;  3'h1: tab4 = 4'h9;  3'h2: tab4 = 4'h5;
      3'h3: tab4 = 4'hC;  3'h4: tab4 = 4'hD;  3'h5: tab4 = 4'hA;
      3'h6: tab4 = 4'h6;  default: tab4 = 4'hE;
    endcase
  endfunction

  logic [4:0] x;
  logic [2:0] y;
  logic       k28;
  logic       k_ok;
  logic [5:0] v6;
  logic [3:0] v4;
  logic       rd_mid;
  logic       alt7;
  logic [9:0] next_code;
  logic       next_rd;

  // Data or special rules pick the sub-blocks; disparity picks the variant.
  always_comb begin
    x = data[4:0];
    y = data[7:5];
    k28 = is_k && (x == 5'h1C);
    k_ok = k28 || ((y == 3'h7) &&
           (x == 5'h17 || x == 5'h1B || x == 5'h1D || x == 5'h1E));
    v6 = k28 ? 6'h0F : tab6(x);
    if (rd && (($countones(v6) != 3) || (x == 5'h07 && !k28))) begin
      v6 = ~v6;
    end
    rd_mid = ($countones(v6) != 3) ? ~rd : rd;
    alt7 = (y == 3'h7) && (is_k || (!rd_mid && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
           (rd_mid && (x == 5'h0B || x == 5'h0D || x == 5'h0E)));
    v4 = alt7 ? 4'h7 : tab4(y);
    if (rd_mid ? (($countones(v4) != 2) || y == 3'h3)
               : (k28 && ($countones(v4) == 2) && y != 3'h3)) begin
      v4 = ~v4;
    end
    next_code = {v4[0], v4[1], v4[2], v4[3],
                 v6[0], v6[1], v6[2], v6[3], v6[4], v6[5]};
    next_rd = ($countones(v4) != 2) ? ~rd_mid : rd_mid;
    if (bypass) begin
      next_code = raw;
      next_rd = rd;
    end else if (viol || (is_k && !k_ok)) begin
      next_code = rd ? qtx_pkg::VIOL_RD_POS : qtx_pkg::VIOL_RD_NEG;
      next_rd = rd;
    end
  end

  // Code and running disparity update once per character.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code <= 10'h000;
      rd <= 1'b0;
    end else if (load) begin
      code <= next_code;
      rd <= next_rd;
    end
  end

  // A freshly encoded character is always near balanced.
  property p_enc_balance;
    @(posedge pclk) disable iff (!presetn)
    (load && !bypass && !viol && (!is_k || k_ok)) |=>
      ($countones(code) >= 4 && $countones(code) <= 6);
  endproperty
  a_enc_balance: assert property (p_enc_balance)
    else $error("encoded character out of balance");

endmodule

/* File: src/qtx_channel.sv */
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
module qtx_channel (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Parallel transmit characters.
  input  wire logic [7:0]  tx_parallel_data_in,
  input  wire logic [1:0]  tx_char_control_in,
  output logic             tx_char_take,
  // Phase-align buffer fault and its flag.
  input  wire logic        align_fault_in,
  output logic             tx_align_error,
  // Serial drivers and loopback path.
  output logic [1:0]       serial_out,
  output logic [1:0]       serial_oe,
  output logic             loopback_out,
  output logic             tx_char_clock_out
);

  logic [qtx_pkg::CTRL_WIDTH-1:0] ctrl;
  logic        encoder_enable_latch;
  logic        tx_selftest_latch;
  logic        local_loopback_enable;
  logic [1:0]  drv_en;
  logic        ref_rate_select;
  logic [1:0]  speed_range_select;
  logic        code_set;
  logic        rx_ref_mode;
  logic        powered;
  logic        cfg_bad;
  logic [4:0]  mult;
  logic [3:0]  bit_cnt;
  logic        take;
  logic [3:0]  ws_left;
  logic        ws_start;
  logic        bist_on;
  logic        bist_pend;
  logic [8:0]  lfsr;
  logic [8:0]  next_lfsr;
  logic        enc_load;
  logic [7:0]  enc_data;
  logic        enc_k;
  logic        enc_viol;
  logic        enc_bypass;
  logic [9:0]  enc_raw;
  logic [9:0]  enc_code;
  logic        enc_rd;
  logic [9:0]  shifter;
  logic        bit_now;
  logic        apb_wr;
  logic        apb_setup;
  logic        align_clr;
  logic [31:0] next_prdata;
  logic        next_slverr;
  logic [8:0]  bist_spec;
  logic [8:0]  host_spec;

  // Special code lookup: set 0 takes the byte as is, set 1 indexes a list.
  function automatic logic [8:0] spec_map(input logic set, input logic [7:0] d);
    logic [3:0] idx;
    idx = d[3:0];
    if (!set) begin
      spec_map = {1'b1, d};
    end else if (d[7:4] != 4'h0 || idx >= qtx_pkg::SET1_COUNT) begin
      spec_map = {1'b0, d};
    end else if (idx < 4'h8) begin
      spec_map = {1'b1, idx[2:0], 5'h1C};
    end else begin
      case (idx[1:0])
        2'h0: spec_map = {1'b1, 8'hF7};
        2'h1: spec_map = {1'b1, 8'hFB};
        2'h2: spec_map = {1'b1, 8'hFD};
        default: spec_map = {1'b1, 8'hFE};
      endcase
    end
  endfunction

  // Control fields.
  assign encoder_enable_latch  = ctrl[qtx_pkg::CTRL_ENC_EN];
  assign tx_selftest_latch     = ctrl[qtx_pkg::CTRL_SELFTEST];
  assign local_loopback_enable = ctrl[qtx_pkg::CTRL_LOOPBACK];
  assign drv_en                = ctrl[qtx_pkg::CTRL_DRV_LO +: 2];
  assign ref_rate_select       = ctrl[qtx_pkg::CTRL_RATE];
  assign speed_range_select    = ctrl[qtx_pkg::CTRL_SPD_LO +: 2];
  assign code_set              = ctrl[qtx_pkg::CTRL_CODE_SET];
  assign rx_ref_mode           = ctrl[qtx_pkg::CTRL_RX_REFCLK];

  // Channel logic runs only while a driver is on; status decoding.
  assign powered = |drv_en;
  assign mult = ref_rate_select ? qtx_pkg::MULT_HALF : qtx_pkg::MULT_FULL;
  assign cfg_bad = (speed_range_select == qtx_pkg::SPD_LOW && ref_rate_select) ||
                   (speed_range_select == 2'h3);
  assign take = powered && (bit_cnt == qtx_pkg::TAKE_PT);
  assign enc_load = powered && (bit_cnt == qtx_pkg::ENC_PT);
  assign bist_on = tx_selftest_latch;

  // Special code lookups for the self-test pattern and for the host byte.
  assign bist_spec = spec_map(1'b1, {4'h0, lfsr[3:0]});
  assign host_spec = spec_map(code_set, tx_parallel_data_in);

  // APB phases and accesses.
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pready && pwrite;
  assign align_clr = apb_wr && (paddr == qtx_pkg::ADDR_CTRL) &&
                     !pwdata[qtx_pkg::CTRL_ALIGN_RST];

  // Read data and error for the access phase that follows.
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_slverr = 1'b0;
    if (paddr == qtx_pkg::ADDR_CTRL) begin
      next_prdata[qtx_pkg::CTRL_WIDTH-1:0] = ctrl;
    end else if (paddr == qtx_pkg::ADDR_STATUS) begin
      next_prdata[qtx_pkg::STAT_ALIGN_ERR] = tx_align_error;
      next_prdata[qtx_pkg::STAT_WS_ACTIVE] = (ws_left != 4'h0);
      next_prdata[qtx_pkg::STAT_SELFTEST] = bist_on;
      next_prdata[qtx_pkg::STAT_DISPARITY] = enc_rd;
      next_prdata[qtx_pkg::STAT_POWERED] = powered;
      next_prdata[qtx_pkg::STAT_CFG_BAD] = cfg_bad;
      next_prdata[qtx_pkg::STAT_MULT_LO +: 5] = mult;
    end else begin
      next_slverr = 1'b1;
    end
  end

  // APB answer registers: one wait-free access phase per transfer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup;
      prdata <= (apb_setup && !pwrite) ? next_prdata : 32'h0000_0000;
      pslverr <= apb_setup && next_slverr;
    end
  end

  // Control register; reset turns off self-test and every driver.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= qtx_pkg::CTRL_RESET;
    end else if (apb_wr && paddr == qtx_pkg::ADDR_CTRL) begin
      ctrl <= pwdata[qtx_pkg::CTRL_WIDTH-1:0];
    end
  end

  // Align error: set by a fault, cleared by buffer reset or a sync start.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_align_error <= 1'b0;
    end else if (align_fault_in) begin
      tx_align_error <= 1'b1;
    end else if (align_clr || ws_start) begin
      tx_align_error <= 1'b0;
    end
  end

  // Bit counter forms the character period; held at zero when powered down.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt <= 4'h0;
    end else if (!powered || bit_cnt == qtx_pkg::BIT_LAST) begin
      bit_cnt <= 4'h0;
    end else begin
      bit_cnt <= bit_cnt + 4'h1;
    end
  end

  // Character clock and the sampling strobe for the host.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_char_clock_out <= 1'b0;
      tx_char_take <= 1'b0;
    end else begin
      tx_char_clock_out <= powered && (bit_cnt < qtx_pkg::CLK_HALF);
      tx_char_take <= powered && (bit_cnt == qtx_pkg::TAKE_PRE);
    end
  end

  // A sync starts on request or on a pending self-test pass while rx_ref_mode is set, only while no sequence is running.
  always_comb begin
    ws_start = 1'b0;
    if (take && ws_left == 4'h0) begin
      if (bist_on) begin
        ws_start = bist_pend && rx_ref_mode;
      end else if (encoder_enable_latch) begin
        ws_start = (tx_char_control_in == qtx_pkg::CT_SYNC);
      end
    end
  end

  // Remaining characters of the running sync sequence.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ws_left <= 4'h0;
    end else if (ws_start) begin
      ws_left <= qtx_pkg::WS_REST;
    end else if (take && ws_left != 4'h0) begin
      ws_left <= ws_left - 4'h1;
    end
  end

  // Pattern register steps once per self-test character.
  assign next_lfsr = {lfsr[7:0], lfsr[8] ^ lfsr[4]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsr <= qtx_pkg::LFSR_SEED;
      bist_pend <= 1'b0;
    end else if (!bist_on) begin
      lfsr <= qtx_pkg::LFSR_SEED;
      bist_pend <= 1'b1;
    end else if (ws_start) begin
      bist_pend <= 1'b0;
    end else if (take && ws_left == 4'h0 && !tx_align_error) begin
      lfsr <= next_lfsr;
      bist_pend <= (next_lfsr == qtx_pkg::LFSR_SEED);
    end
  end

  // Character choice at each sampling point, by priority.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enc_data <= 8'h00;
      enc_k <= 1'b0;
      enc_viol <= 1'b0;
      enc_bypass <= 1'b0;
      enc_raw <= 10'h000;
    end else if (take) begin
      enc_data <= qtx_pkg::K28_5;
      enc_k <= 1'b1;
      enc_viol <= 1'b0;
      enc_bypass <= 1'b0;
      enc_raw <= {tx_char_control_in, tx_parallel_data_in};
      if (ws_start || ws_left != 4'h0) begin
        enc_k <= 1'b1;
      end else if (tx_align_error) begin
        enc_viol <= 1'b1;
      end else if (bist_on) begin
        enc_k <= lfsr[8];
        enc_data <= lfsr[8] ? bist_spec[7:0] : lfsr[7:0];
        enc_viol <= lfsr[8] && !bist_spec[8];
      end else if (!encoder_enable_latch) begin
        enc_bypass <= 1'b1;
      end else begin
        unique case (tx_char_control_in)
          qtx_pkg::CT_DATA: begin
            enc_k <= 1'b0;
            enc_data <= tx_parallel_data_in;
          end
          qtx_pkg::CT_FILL: enc_data <= qtx_pkg::K28_5;
          qtx_pkg::CT_SPEC: begin
            enc_data <= host_spec[7:0];
            enc_viol <= !host_spec[8];
          end
          qtx_pkg::CT_SYNC: enc_data <= qtx_pkg::K28_5;
        endcase
      end
    end
  end

  qtx_encoder u_enc (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (enc_load),
    .data    (enc_data),
    .is_k    (enc_k),
    .viol    (enc_viol),
    .bypass  (enc_bypass),
    .raw     (enc_raw),
    .code    (enc_code),
    .rd      (enc_rd)
  );

  // Shifter loads each code and sends bit a first.
  assign bit_now = (bit_cnt == 4'h0) ? enc_code[0] : shifter[bit_cnt];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shifter <= 10'h000;
      loopback_out <= 1'b0;
    end else begin
      if (powered && bit_cnt == 4'h0) begin
        shifter <= enc_code;
      end
      loopback_out <= powered && bit_now;
    end
  end

  // Each driver follows its enable; loopback forces a static one.
  for (genvar i = 0; i < 2; i++) begin : g_drv
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        serial_out[i] <= 1'b0;
        serial_oe[i] <= 1'b0;
      end else begin
        serial_oe[i] <= drv_en[i];
        serial_out[i] <= drv_en[i] && (local_loopback_enable || bit_now);
      end
    end
  end

  // Code bits a and b leave at the first two bit slots.
  property p_lsb_first;
    @(posedge pclk) disable iff (!presetn)
    (powered && bit_cnt == 4'h0 && !local_loopback_enable && drv_en[0]) |=>
      serial_out[0] == $past(enc_code[0]) ##1
      serial_out[0] == ($past(drv_en[0]) && ($past(local_loopback_enable) || $past(shifter[1])));
  endproperty
  a_lsb_first: assert property (p_lsb_first)
    else $error("serial order is not LSB first");

  property p_bypass_raw;
    @(posedge pclk) disable iff (!presetn)
    (take && !encoder_enable_latch && !bist_on && !tx_align_error &&
     ws_left == 4'h0 && !align_fault_in) |=> ##1
      enc_code == {$past(tx_char_control_in, 2), $past(tx_parallel_data_in, 2)};
  endproperty
  a_bypass_raw: assert property (p_bypass_raw)
    else $error("bypass character altered");

  property p_fill;
    @(posedge pclk) disable iff (!presetn)
    (take && encoder_enable_latch && !bist_on && !tx_align_error && ws_left == 4'h0 &&
     tx_char_control_in == qtx_pkg::CT_FILL) |=> enc_k && enc_data == qtx_pkg::K28_5;
  endproperty
  a_fill: assert property (p_fill)
    else $error("fill request did not give K28.5");

  property p_ws_start;
    @(posedge pclk) disable iff (!presetn)
    ws_start |=> ws_left == qtx_pkg::WS_REST && enc_k && enc_data == qtx_pkg::K28_5;
  endproperty
  a_ws_start: assert property (p_ws_start)
    else $error("sync sequence did not start full");

  property p_ws_hold;
    @(posedge pclk) disable iff (!presetn)
    (take && ws_left != 4'h0) |=> enc_k && !enc_viol && !enc_bypass &&
      enc_data == qtx_pkg::K28_5 && ws_left == $past(ws_left) - 4'h1;
  endproperty
  a_ws_hold: assert property (p_ws_hold)
    else $error("sync sequence interrupted");

  property p_err_viol;
    @(posedge pclk) disable iff (!presetn)
    (take && tx_align_error && !ws_start && ws_left == 4'h0) |=> enc_viol;
  endproperty
  a_err_viol: assert property (p_err_viol)
    else $error("align error without violation character");

  property p_bist_ignore;
    @(posedge pclk) disable iff (!presetn)
    (take && bist_on && !lfsr[8] && !ws_start && ws_left == 4'h0 && !tx_align_error) |=>
      !enc_k && !enc_bypass && enc_data == $past(lfsr[7:0]);
  endproperty
  a_bist_ignore: assert property (p_bist_ignore)
    else $error("self-test character taken from inputs");

  property p_loop;
    @(posedge pclk) disable iff (!presetn)
    (local_loopback_enable && drv_en[1]) |=> serial_out[1] && serial_oe[1];
  endproperty
  a_loop: assert property (p_loop)
    else $error("loopback driver not static");

  property p_drv_off;
    @(posedge pclk) disable iff (!presetn)
    (drv_en == 2'h0) |=> (serial_oe == 2'h0) && (serial_out == 2'h0) && !tx_char_take;
  endproperty
  a_drv_off: assert property (p_drv_off)
    else $error("disabled channel still active");

  c_ws_restart: cover property (@(posedge pclk) disable iff (!presetn)
    (take && ws_left == 4'h1) ##[1:20] ws_start);
  c_bist_wrap: cover property (@(posedge pclk) disable iff (!presetn)
    bist_on && take && lfsr == qtx_pkg::LFSR_SEED && ws_left == 4'h0);
  c_err_clear: cover property (@(posedge pclk) disable iff (!presetn)
    tx_align_error ##1 !tx_align_error);

endmodule

/* File: tb/qtx_host_model.sv */
`timescale 1ns/1ps
// Host that holds one character until it is taken, then presents idle D21.5 data.
module qtx_host_model (
  // Clock and reset.
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Load request from the bench and the character taken by the channel.
  input  wire logic       tx_char_take,
  input  wire logic       ld,
  input  wire logic [9:0] nxt,
  output logic      [9:0] chr
);
  // The held character is released right after the channel takes it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) chr <= 10'h0B5;
    else if (ld) chr <= nxt;
    else if (tx_char_take) chr <= 10'h0B5;
  end
endmodule

/* File: tb/qtx_channel_tb_top.sv */
`timescale 1ns/1ps
// Drives APB and the host model, and reads driver 0 bit by bit.
module qtx_channel_tb_top;
  logic        pclk = 0, presetn = 1, psel = 0, penable = 0, pwrite = 0, ld = 0, flt = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [9:0]  nxt = 10'h000, chr, c, cl;
  logic [1:0]  sout, soe;
  logic        pready, pslverr, err, take, aerr, lpo, cko;
  int          n_fail = 0, checked = 0, cyc = 0, n_hi = 0;
  // Clock and instances.
  always #5 pclk = ~pclk;
  qtx_host_model u_qtx_host_model (.pclk(pclk), .presetn(presetn), .tx_char_take(take),
    .ld(ld), .nxt(nxt), .chr(chr));
  qtx_channel u_qtx_channel (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_parallel_data_in(chr[7:0]), .tx_char_control_in(chr[9:8]),
    .tx_char_take(take), .align_fault_in(flt), .tx_align_error(aerr), .serial_out(sout),
    .serial_oe(soe), .loopback_out(lpo), .tx_char_clock_out(cko));
  // Verdict and end of run.
  task complete_run;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Cycle ceiling against hangs.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      complete_run;
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One APB transfer, held until pready is seen high; an idle edge follows it.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Ten bits of driver 0 and of the loopback path, bit a first, read one edge after launch.
  task cap(input logic [9:0] e);
    for (int i = 0; i < 10; i++) begin
      @(posedge pclk);
      c[i] = sout[0];
      cl[i] = lpo;
    end
    chk(c, e);
    chk(cl, e);
  endtask
  // Present a character, wait for its take, then read what it became.
  task snd(input logic [9:0] v, input logic [9:0] e);
    ld <= 1'b1;
    nxt <= v;
    @(posedge pclk) ld <= 1'b0;
    do @(negedge pclk); while (take !== 1'b1);
    @(posedge pclk);
    @(posedge pclk);
    @(posedge pclk);
    cap(e);
  endtask
  // Test sequence.
  initial begin
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, qtx_pkg::ADDR_CTRL, 0);
    chk(rd, 32'h201);
    chk(soe, 2'b00);
    apb(1, qtx_pkg::ADDR_CTRL, 32'h218);
    snd(10'h2A5, 10'h2A5);
    chk(soe, 2'b11);
    $display("test bypass done");
    apb(1, qtx_pkg::ADDR_CTRL, 32'h219);
    snd(10'h1BC, 10'h17C);
    snd(10'h100, 10'h283);
    snd(10'h0B5, 10'h155);
    snd(10'h2BC, 10'h17C);
    apb(1, qtx_pkg::ADDR_CTRL, 32'h319);
    snd(10'h205, 10'h283);
    $display("test encoder done");
    snd(10'h300, 10'h17C);
    for (int k = 1; k < 32; k++) begin
      if (k == 15) begin
        ld <= 1'b1;
        nxt <= 10'h300;
      end
      if (k == 16) begin
        ld <= 1'b0;
      end
      cap(k[0] ? 10'h283 : 10'h17C);
    end
    cap(10'h155);
    $display("test sync done");
    apb(1, qtx_pkg::ADDR_CTRL, 32'h31D);
    repeat (2) @(posedge pclk);
    for (int k = 0; k < 8; k++) begin
      @(posedge pclk);
      chk(sout, 2'b11);
    end
    for (int k = 0; k < 10; k++) begin
      @(posedge pclk);
      n_hi += cko;
    end
    chk(n_hi, 5);
    apb(1, qtx_pkg::ADDR_CTRL, 32'h319);
    apb(0, qtx_pkg::ADDR_STATUS, 0);
    chk(rd & 32'h1F20, 32'h0A00);
    apb(1, qtx_pkg::ADDR_CTRL, 32'h379);
    apb(0, qtx_pkg::ADDR_STATUS, 0);
    chk(rd & 32'h1F20, 32'h1400);
    apb(1, qtx_pkg::ADDR_CTRL, 32'h319);
    $display("test loopback and rate done");
    flt <= 1'b1;
    @(posedge pclk) flt <= 1'b0;
    snd(10'h0B5, 10'h2F8);
    chk(aerr, 1'b1);
    apb(1, qtx_pkg::ADDR_CTRL, 32'h119);
    repeat (2) @(posedge pclk);
    chk(aerr, 1'b0);
    apb(0, 8'h08, 0);
    chk(rd, 32'h0);
    chk(err, 1'b1);
    apb(1, qtx_pkg::ADDR_CTRL, 32'h71B);
    repeat (12) @(posedge pclk);
    apb(0, qtx_pkg::ADDR_STATUS, 0);
    chk(rd & 32'h6, 32'h6);
    $display("test fault and self-test done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(soe, 2'b00);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, qtx_pkg::ADDR_STATUS, 0);
    chk(rd & 32'h4, 32'h0);
    $display("test second reset done");
    complete_run;
  end
endmodule
